// File: hw/smpw_core.sv
`timescale 1ns/100ps
`include "smpw_cfg.svh"
module smpw_core #(
  parameter int KICK_CYC = `SMPW_KICK_CYC,
  parameter int BITE_CYC = `SMPW_BITE_CYC,
  parameter int GAP_CYC  = `SMPW_GAP_CYC
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Byte command port from the serial engine.
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_common,
  input  wire logic        cmd_on_page,
  output logic      [7:0]  cmd_rdata,
  output logic             cmd_rvalid,
  output logic             cmd_invalid,
  // Memory check and configuration reload.
  input  wire logic        mem_check_done,
  input  wire logic        mem_check_ok,
  output logic             cfg_reload,
  input  wire logic        cfg_reload_done,
  // Watchdog restart from normal operation.
  input  wire logic        wdog_kick,
  // Per channel configuration.
  input  wire logic [11:0] fault_drive_en,
  input  wire logic [11:0] fault_resp_en,
  input  wire logic [11:0] chan_fault,
  input  wire logic [11:0] seq_wait_en,
  input  wire logic [11:0] sig_emit_en,
  input  wire logic [47:0] sig_code,
  input  wire logic [47:0] sig_wait_code,
  input  wire logic [15:0] event_wait_limit,
  input  wire logic [11:0] power_good,
  input  wire logic [11:0] chan_start,
  input  wire logic        second_fault_en,
  input  wire logic        third_fault_en,
  input  wire logic        alert_en,
  input  wire logic        clear_faults,
  // Shared lines, active low open drain.
  input  wire logic        onoff_line_zero,
  input  wire logic        onoff_line_one,
  input  wire logic [2:0]  shared_shutdown_line_in,
  output logic      [2:0]  shared_shutdown_line_out,
  output logic      [2:0]  shared_shutdown_line_oe_n,
  input  wire logic        order_signature_line_in,
  output logic             order_signature_line_out,
  output logic             order_signature_line_oe_n,
  // Supply outputs.
  output logic      [11:0] supply_enable_out,
  output logic      [11:0] supply_enable_oe_n,
  output logic      [7:0]  margin_drive_out,
  output logic      [7:0]  margin_drive_oe_n,
  output logic      [11:0] seq_timeout,
  // Page decode.
  output logic      [3:0]  page_target,
  output logic      [4:0]  page_index,
  output logic      [7:0]  page_bus_addr,
  output logic             page_all,
  output logic             page_gpio_cfg,
  // Status.
  output logic             status_cml,
  output logic             vendor_summary_flag,
  output logic             wdog_flag,
  output logic             alert_n,
  output logic             chip_reset
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    smpw_pkg::smpw_state_e st;
    logic [7:0]            channel_select_reg;
    logic [31:0]           wdog_cnt;
    logic                  wdog_flag;
    logic                  summary;
    logic                  cml;
    logic                  alert_n;
    logic                  chip_reset;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  invalid;
    smpw_pkg::smpw_chan_e [11:0] ch;
    logic [11:0][15:0]     wait_cnt;
    logic [11:0]           tmo;
    logic [11:0]           pg_d;
    logic [3:0]            rx_sig;
    logic [3:0]            rx_bit;
    logic [15:0]           rx_cnt;
    logic                  rx_d;
    logic                  rx_hit;
    logic [3:0]            tx_sig;
    logic [4:0]            tx_bit;
    logic [15:0]           tx_cnt;
    logic [31:0]           tx_gap;
    logic [11:0]           tx_pend;
    logic                  tx_lvl;
    logic [2:0]            flt_out;
    logic [11:0]           en;
    logic [7:0]            pwm_oe_n;
    logic [11:0]           en_oe_n;
    logic [2:0]            flt_oe_n;
    logic                  seq_oe_n;
    logic [3:0]            tgt;
    logic [4:0]            idx;
    logic [7:0]            baddr;
    logic                  all;
    logic                  gpio;
  } smpw_state_s;

  smpw_state_s s_reg;
  smpw_state_s s_next;

  // Page range decode used by the page write check; the target map compares the page itself.
  function automatic logic page_valid(input logic [7:0] p);
    page_valid = (p <= `SMPW_PAGE_LAST) || (p == `SMPW_PAGE_ALL);
  endfunction : page_valid

  function automatic logic [3:0] sig_of(input logic [47:0] v, input int i);
    sig_of = v[i*4 +: 4];
  endfunction : sig_of

  logic [2:0] fault_seen;
  logic       on_cmd;
  logic       run;

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.invalid = 1'b0;
    s_next.chip_reset = 1'b0;
    run = (s_reg.st == smpw_pkg::SMPW_RUN);
    on_cmd = !onoff_line_zero || !onoff_line_one;
    fault_seen = ~shared_shutdown_line_in;
    fault_seen[1] = fault_seen[1] & second_fault_en;
    fault_seen[2] = fault_seen[2] & third_fault_en;

    unique case (s_reg.st)
      smpw_pkg::SMPW_CHECK: begin
        if (mem_check_done) begin
          s_next.st = mem_check_ok ? smpw_pkg::SMPW_RELOAD
                                   : smpw_pkg::SMPW_NULL;
        end
      end
      smpw_pkg::SMPW_RELOAD: begin
        if (cfg_reload_done) begin
          s_next.st = smpw_pkg::SMPW_RUN;
          s_next.wdog_cnt = '0;
        end
      end
      smpw_pkg::SMPW_RUN: begin
        if (wdog_kick) begin
          s_next.wdog_cnt = '0;
        end else if (s_reg.wdog_cnt >= 32'(BITE_CYC - 1)) begin
          s_next.st = smpw_pkg::SMPW_RELOAD;
          s_next.chip_reset = 1'b1;
          s_next.wdog_flag = 1'b1;
          s_next.summary = 1'b1;
          s_next.alert_n = !alert_en;
          s_next.channel_select_reg = `SMPW_PAGE_RST;
          s_next.en = '0;
          for (int i = 0; i < `SMPW_NCH; i++) begin
            s_next.ch[i] = smpw_pkg::SMPW_SEQ_IDLE;
          end
        end else begin
          s_next.wdog_cnt = s_reg.wdog_cnt + 32'h1;
        end
      end
      smpw_pkg::SMPW_NULL: begin
        s_next.st = smpw_pkg::SMPW_NULL;
      end
      default: s_next.st = smpw_pkg::SMPW_CHECK;
    endcase

    // A clear is applied first so a same-cycle event still lands.
    if (clear_faults && run && cmd_wr == 1'b0) begin
      s_next.cml = 1'b0;
      s_next.wdog_flag = 1'b0;
      s_next.summary = 1'b0;
      s_next.alert_n = 1'b1;
      if (s_reg.wdog_cnt >= 32'(BITE_CYC - 1) && !wdog_kick) begin
        s_next.wdog_flag = 1'b1;
        s_next.summary = 1'b1;
        s_next.alert_n = !alert_en;
      end
    end

    // Page register and command checks.
    if (cmd_wr && run) begin
      if (cmd_code == `SMPW_CMD_PAGE) begin
        if (page_valid(cmd_data)) begin
          s_next.channel_select_reg = cmd_data;
        end else begin
          s_next.invalid = 1'b1;
          s_next.cml = 1'b1;
          s_next.alert_n = !alert_en;
        end
      end else if (!cmd_common && !cmd_on_page) begin
        s_next.cml = 1'b1;
        s_next.alert_n = !alert_en;
      end
    end
    if (cmd_rd && run) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = (cmd_code == `SMPW_CMD_PAGE) ? s_reg.channel_select_reg
                                                  : 8'h00;
      if (cmd_code != `SMPW_CMD_PAGE && !cmd_common && !cmd_on_page) begin
        s_next.cml = 1'b1;
        s_next.alert_n = !alert_en;
      end
    end
    // Page map.
    s_next.all = (s_next.channel_select_reg == `SMPW_PAGE_ALL);
    s_next.gpio = (s_next.channel_select_reg <= `SMPW_PAGE_LAST_SUP);
    s_next.idx = s_next.channel_select_reg[4:0];
    s_next.baddr = 8'h00;
    if (s_next.channel_select_reg <= `SMPW_PAGE_LAST_SUP) begin
      s_next.tgt = smpw_pkg::SMPW_TGT_SUPPLY;
      if (s_next.channel_select_reg > `SMPW_PAGE_LAST_PWM) begin
        s_next.baddr = `SMPW_DAC_ADDR;
      end
    end else if (s_next.channel_select_reg <= `SMPW_PAGE_LAST_ADC) begin
      s_next.tgt = smpw_pkg::SMPW_TGT_ADC;
    end else if (s_next.channel_select_reg <= `SMPW_PAGE_LAST) begin
      s_next.tgt = smpw_pkg::SMPW_TGT_TEMP;
      if (s_next.channel_select_reg != `SMPW_PAGE_INT_TEMP) begin
        s_next.baddr = 8'(`SMPW_TEMP_ADDR0 + {s_next.channel_select_reg
                          - `SMPW_PAGE_INT_TEMP - 8'h01, 1'b0});
      end
    end else begin
      s_next.tgt = smpw_pkg::SMPW_TGT_NONE;
    end

    // Fault lines driven by faulting supplies.
    s_next.flt_out = '0;
    for (int i = 0; i < `SMPW_NCH; i++) begin
      if (chan_fault[i] && fault_drive_en[i] && run) begin
        s_next.flt_out = 3'b111;
      end
    end
    s_next.flt_out[1] = s_next.flt_out[1] & second_fault_en;
    s_next.flt_out[2] = s_next.flt_out[2] & third_fault_en;

    // Signature receiver: low pulses counted until a slot and a half passes without one.
    s_next.rx_d = order_signature_line_in;
    s_next.rx_hit = 1'b0;
    if (s_reg.rx_d && !order_signature_line_in) begin
      s_next.rx_bit = s_reg.rx_bit + 4'h1;
      // The window outlasts one slot so pulses of one code stay together.
      s_next.rx_cnt = `SMPW_SIG_CYC + (`SMPW_SIG_CYC >> 1);
    end else if (s_reg.rx_cnt != 16'h0) begin
      s_next.rx_cnt = s_reg.rx_cnt - 16'h1;
      if (s_reg.rx_cnt == 16'h1) begin
        s_next.rx_sig = s_reg.rx_bit;
        s_next.rx_hit = 1'b1;
        s_next.rx_bit = 4'h0;
      end
    end

    // Signature sender.
    s_next.pg_d = power_good;
    s_next.tx_pend = s_reg.tx_pend
                     | (power_good & ~s_reg.pg_d & sig_emit_en);
    s_next.tx_lvl = 1'b1;
    if (s_reg.tx_bit != 5'h0) begin
      s_next.tx_lvl = (s_reg.tx_cnt > (`SMPW_SIG_CYC >> 1));
      if (s_reg.tx_cnt == 16'h0) begin
        s_next.tx_cnt = `SMPW_SIG_CYC;
        s_next.tx_bit = s_reg.tx_bit - 5'h1;
      end else begin
        s_next.tx_cnt = s_reg.tx_cnt - 16'h1;
      end
      s_next.tx_gap = 32'(GAP_CYC);
    end else if (s_reg.tx_gap != 32'h0) begin
      s_next.tx_gap = s_reg.tx_gap - 32'h1;
    end else begin
      for (int i = `SMPW_NCH - 1; i >= 0; i--) begin
        if (s_next.tx_pend[i] && sig_of(sig_code, i) != 4'h0) begin
          s_next.tx_sig = sig_of(sig_code, i);
          s_next.tx_bit = {1'b0, sig_of(sig_code, i)};
          s_next.tx_cnt = `SMPW_SIG_CYC;
        end
      end
      s_next.tx_pend = '0;
    end

    // Per channel sequencing.
    for (int i = 0; i < `SMPW_NCH; i++) begin
      s_next.tmo[i] = 1'b0;
      unique case (s_reg.ch[i])
        smpw_pkg::SMPW_SEQ_IDLE: begin
          if (run && chan_start[i] && on_cmd && !(|fault_seen)) begin
            s_next.wait_cnt[i] = event_wait_limit;
            s_next.ch[i] = seq_wait_en[i] ? smpw_pkg::SMPW_SEQ_WAIT
                                          : smpw_pkg::SMPW_SEQ_ON;
          end
        end
        smpw_pkg::SMPW_SEQ_WAIT: begin
          if (s_reg.rx_hit && s_reg.rx_sig == sig_of(sig_wait_code, i)) begin
            s_next.ch[i] = smpw_pkg::SMPW_SEQ_ON;
          end else if (event_wait_limit != 16'h0) begin
            if (s_reg.wait_cnt[i] == 16'h0) begin
              s_next.tmo[i] = 1'b1;
              s_next.ch[i] = smpw_pkg::SMPW_SEQ_IDLE;
            end else begin
              s_next.wait_cnt[i] = s_reg.wait_cnt[i] - 16'h1;
            end
          end
        end
        smpw_pkg::SMPW_SEQ_ON: begin
          s_next.ch[i] = smpw_pkg::SMPW_SEQ_ON;
        end
        default: s_next.ch[i] = smpw_pkg::SMPW_SEQ_IDLE;
      endcase
      if (!on_cmd || (fault_resp_en[i] && |fault_seen)) begin
        s_next.ch[i] = smpw_pkg::SMPW_SEQ_IDLE;
      end
      s_next.en[i] = (s_next.ch[i] == smpw_pkg::SMPW_SEQ_ON);
    end

    // Pin release: a failed check floats all but the primary fault line.
    s_next.en_oe_n = (s_next.st == smpw_pkg::SMPW_RUN) ? 12'h000 : 12'hFFF;
    s_next.pwm_oe_n = (s_next.st == smpw_pkg::SMPW_RUN) ? 8'h00 : 8'hFF;
    s_next.en_oe_n[`SMPW_PSEN_TEN] = s_next.en_oe_n[`SMPW_PSEN_TEN]
                                     | third_fault_en;
    s_next.pwm_oe_n[`SMPW_PWM_SEVEN] = s_next.pwm_oe_n[`SMPW_PWM_SEVEN]
                                       | second_fault_en;
    s_next.flt_oe_n = ~s_next.flt_out;
    s_next.seq_oe_n = s_next.tx_lvl;
    if (s_next.st == smpw_pkg::SMPW_NULL) begin
      s_next.flt_oe_n = 3'b110;
      s_next.seq_oe_n = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= smpw_pkg::SMPW_CHECK;
      s_reg.channel_select_reg <= `SMPW_PAGE_RST;
      s_reg.alert_n <= 1'b1;
      s_reg.rx_d <= 1'b1;
      s_reg.tx_lvl <= 1'b1;
      s_reg.tgt <= smpw_pkg::SMPW_TGT_SUPPLY;
      s_reg.gpio <= 1'b1;
      s_reg.en_oe_n <= 12'hFFF;
      s_reg.pwm_oe_n <= 8'hFF;
      s_reg.flt_oe_n <= 3'b111;
      s_reg.seq_oe_n <= 1'b1;
      for (int i = 0; i < `SMPW_NCH; i++) begin
        s_reg.ch[i] <= smpw_pkg::SMPW_SEQ_IDLE;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come from the state flops; the shutdown, signature and margin drive values are tied low.
  assign cmd_rdata = s_reg.rdata;
  assign cmd_rvalid = s_reg.rvalid;
  assign cmd_invalid = s_reg.invalid;
  assign cfg_reload = (s_reg.st == smpw_pkg::SMPW_RELOAD);
  assign shared_shutdown_line_out = 3'b000;
  assign shared_shutdown_line_oe_n = s_reg.flt_oe_n;
  assign order_signature_line_out = 1'b0;
  assign order_signature_line_oe_n = s_reg.seq_oe_n;
  assign supply_enable_out = s_reg.en;
  assign supply_enable_oe_n = s_reg.en_oe_n;
  assign margin_drive_out = 8'h00;
  assign margin_drive_oe_n = s_reg.pwm_oe_n;
  assign seq_timeout = s_reg.tmo;
  assign page_target = s_reg.tgt;
  assign page_index = s_reg.idx;
  assign page_bus_addr = s_reg.baddr;
  assign page_all = s_reg.all;
  assign page_gpio_cfg = s_reg.gpio;
  assign status_cml = s_reg.cml;
  assign vendor_summary_flag = s_reg.summary;
  assign wdog_flag = s_reg.wdog_flag;
  assign alert_n = s_reg.alert_n;
  assign chip_reset = s_reg.chip_reset;

endmodule : smpw_core

// File: common/smpw_cfg.svh
`ifndef SMPW_CFG_SVH
`define SMPW_CFG_SVH
`define SMPW_CLK_MHZ        40
`define SMPW_KICK_US        5000
`define SMPW_BITE_US        210000
`define SMPW_KICK_CYC       (`SMPW_KICK_US * `SMPW_CLK_MHZ)
`define SMPW_BITE_CYC       (`SMPW_BITE_US * `SMPW_CLK_MHZ)
`define SMPW_GAP_US         15000
`define SMPW_GAP_CYC        (`SMPW_GAP_US * `SMPW_CLK_MHZ)
`define SMPW_SIG_CYC        16'h4000
`define SMPW_PAGE_RST       8'h00
`define SMPW_PAGE_LAST_SUP  8'h0B
`define SMPW_PAGE_LAST_PWM  8'h07
`define SMPW_PAGE_LAST_ADC  8'h0F
`define SMPW_PAGE_INT_TEMP  8'h10
`define SMPW_PAGE_LAST      8'h14
`define SMPW_PAGE_ALL       8'hFF
`define SMPW_DAC_ADDR       8'hA0
`define SMPW_TEMP_ADDR0     8'h90
`define SMPW_CMD_PAGE       8'h00
`define SMPW_NCH            12
`define SMPW_RELOAD_CYC     8'h10
`define SMPW_PWM_SEVEN      7
`define SMPW_PSEN_TEN       10
`endif

// File: common/smpw_pkg.sv
package smpw_pkg;
  typedef enum logic [3:0] {
    SMPW_CHECK  = 4'b0001,
    SMPW_RELOAD = 4'b0010,
    SMPW_RUN    = 4'b0100,
    SMPW_NULL   = 4'b1000
  } smpw_state_e;

  typedef enum logic [2:0] {
    SMPW_SEQ_IDLE = 3'b001,
    SMPW_SEQ_WAIT = 3'b010,
    SMPW_SEQ_ON   = 3'b100
  } smpw_chan_e;

  typedef enum logic [3:0] {
    SMPW_TGT_SUPPLY = 4'b0001,
    SMPW_TGT_ADC    = 4'b0010,
    SMPW_TGT_TEMP   = 4'b0100,
    SMPW_TGT_NONE   = 4'b1000
  } smpw_tgt_e;
endpackage : smpw_pkg

// File: test/smpw_checker.sv
`timescale 1ns/100ps
module smpw_checker #(
  parameter int BITE_CYC = 200
) (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Command port.
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic [7:0]  cmd_code,
  input wire logic [7:0]  cmd_data,
  input wire logic        cmd_common,
  input wire logic        cmd_on_page,
  input wire logic        cmd_invalid,
  // Start-up and watchdog.
  input wire logic        mem_check_done,
  input wire logic        mem_check_ok,
  input wire logic        cfg_reload,
  input wire logic        wdog_kick,
  input wire logic        chip_reset,
  input wire logic        alert_en,
  // Shared pins.
  input wire logic        third_fault_en,
  input wire logic [2:0]  shared_shutdown_line_oe_n,
  input wire logic [11:0] supply_enable_oe_n,
  // Page and status.
  input wire logic [3:0]  page_target,
  input wire logic [4:0]  page_index,
  input wire logic [7:0]  page_bus_addr,
  input wire logic        page_all,
  input wire logic        page_gpio_cfg,
  input wire logic        status_cml,
  input wire logic        vendor_summary_flag,
  input wire logic        wdog_flag,
  input wire logic        alert_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic        run;
  logic        pg_wr;
  logic        pg_rsv;
  logic [15:0] idle_cnt_reg;
  assign run = mem_check_ok && !cfg_reload && !chip_reset;
  assign pg_wr = run && cmd_wr && cmd_code == 8'h00;
  assign pg_rsv = pg_wr && cmd_data > 8'h14 && cmd_data != 8'hFF;
  // ****************************************
  // Idle count, a few cycles of skew allowed.
  // ****************************************
  always_ff @(posedge mclk) begin
    if (sys_rst || wdog_kick || cfg_reload || chip_reset || !mem_check_ok) begin
      idle_cnt_reg <= 16'h0000;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
    end
  end
  rst_state_a: assert property (
    $fell(sys_rst) |-> page_index == 5'h00 && alert_n
      && &shared_shutdown_line_oe_n) else $error("bad state after reset");
  page_wr_a: assert property (
    pg_wr && cmd_data <= 8'h14 |=> page_index == $past(cmd_data[4:0])
      && !page_all) else $error("page not taken");
  page_all_a: assert property (
    pg_wr && cmd_data == 8'hFF |=> page_all) else $error("all pages lost");
  rsv_flag_a: assert property (
    pg_rsv |-> ##[1:2] cmd_invalid) else $error("reserved page accepted");
  cmd_cml_a: assert property (
    run && (cmd_wr || cmd_rd) && !cmd_on_page && !cmd_common
      |-> ##[1:2] status_cml) else $error("unsupported not flagged");
  gpio_page_a: assert property (
    !page_all && page_index <= 5'h0B |-> page_gpio_cfg)
    else $error("gpio access missing");
  dac_addr_a: assert property (
    !page_all && page_target == 4'h1 && page_index >= 5'h08
      |-> page_bus_addr == 8'hA0) else $error("dac address wrong");
  temp_addr_a: assert property (
    !page_all && page_target == 4'h4 && page_index >= 5'h11
      |-> page_bus_addr == 8'h90 + {2'b00, page_index - 5'h11, 1'b0})
    else $error("sensor address wrong");
  third_line_a: assert property (
    third_fault_en [*2] |-> supply_enable_oe_n[10])
    else $error("enable ten still driven");
  null_pins_a: assert property (
    (mem_check_done && !mem_check_ok) [*4]
      |-> shared_shutdown_line_oe_n == 3'b110 && &supply_enable_oe_n)
    else $error("null state pins wrong");
  bite_early_a: assert property (
    chip_reset |-> idle_cnt_reg >= 16'(BITE_CYC - 4))
    else $error("watchdog bit early");
  bite_late_a: assert property (
    idle_cnt_reg <= 16'(BITE_CYC + 4)) else $error("watchdog bit late");
  bite_flag_a: assert property (
    chip_reset |-> ##[1:3] wdog_flag && vendor_summary_flag)
    else $error("watchdog flags missing");
  bite_alert_a: assert property (
    chip_reset && alert_en |-> ##[1:3] !alert_n)
    else $error("alert missing");
  cover property (pg_rsv);
  cover property (chip_reset);
  cover property ((mem_check_done && !mem_check_ok) [*4]);
endmodule : smpw_checker

// File: test/smpw_peer.sv
`timescale 1ns/100ps
module smpw_peer (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Bench request to pull shutdown lines.
  input  wire logic [2:0] pull_line,
  // Open-drain drives, low while pulling.
  output logic      [2:0] shutdown_oe_n,
  output logic            sig_oe_n
);
  // Shares reset with the device under test.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shutdown_oe_n <= 3'b111;
    end else begin
      shutdown_oe_n <= ~pull_line;
    end
  end
  // This peer owns no signature, so it never disturbs the line.
  assign sig_oe_n = 1'b1;
endmodule : smpw_peer

// File: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int KICK_CYC = 50;
  localparam int BITE_CYC = 200;
  logic mclk = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0;
  logic cmd_common = 1'b0, cmd_on_page = 1'b1, kick_en = 1'b1;
  logic mem_check_done = 1'b1, mem_check_ok = 1'b1, cfg_reload_done = 1'b1;
  logic wdog_kick = 1'b0, second_fault_en = 1'b0, third_fault_en = 1'b0;
  logic alert_en = 1'b0, clear_faults = 1'b0, onoff_line_zero = 1'b0;
  logic onoff_line_one = 1'b1, cmd_rvalid, cmd_invalid, cfg_reload;
  logic page_all, page_gpio_cfg, status_cml, vendor_summary_flag;
  logic wdog_flag, alert_n, chip_reset, rsv, inv;
  logic [7:0] cmd_code = 8'h00, cmd_data = 8'h00, cmd_rdata, p, cur;
  logic [7:0] page_bus_addr, margin_drive_oe_n;
  logic [11:0] fault_drive_en = '0, fault_resp_en = '0, chan_fault = '0;
  logic [11:0] seq_wait_en = '0, sig_emit_en = '0, power_good = '0;
  logic [11:0] chan_start = '0, supply_enable_out, supply_enable_oe_n;
  logic [11:0] seq_timeout;
  logic [47:0] sig_code = '0, sig_wait_code = '0;
  logic [15:0] event_wait_limit = 16'h0000;
  logic [3:0] page_target;
  logic [4:0] page_index;
  logic [2:0] peer_pull = 3'b000, dev_sd_oe_n, peer_sd_oe_n;
  logic dev_sq_oe_n, peer_sq_oe_n;
  wire [2:0] sd_line = dev_sd_oe_n & peer_sd_oe_n;
  wire sq_line = dev_sq_oe_n & peer_sq_oe_n;
  int failures = 0, num_checks = 0, bites = 0, kcnt = 0, i, n;
  always #12.5 mclk = ~mclk;
  smpw_core #(.KICK_CYC(KICK_CYC), .BITE_CYC(BITE_CYC), .GAP_CYC(100))
  smpw_core_inst (.mclk, .sys_rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_data,
    .cmd_common, .cmd_on_page, .cmd_rdata, .cmd_rvalid, .cmd_invalid,
    .mem_check_done, .mem_check_ok, .cfg_reload, .cfg_reload_done,
    .wdog_kick, .fault_drive_en, .fault_resp_en, .chan_fault,
    .seq_wait_en, .sig_emit_en, .sig_code, .sig_wait_code,
    .event_wait_limit, .power_good, .chan_start, .second_fault_en,
    .third_fault_en, .alert_en, .clear_faults, .onoff_line_zero,
    .onoff_line_one, .shared_shutdown_line_in(sd_line),
    .shared_shutdown_line_out(), .shared_shutdown_line_oe_n(dev_sd_oe_n),
    .order_signature_line_in(sq_line), .order_signature_line_out(),
    .order_signature_line_oe_n(dev_sq_oe_n), .supply_enable_out,
    .supply_enable_oe_n, .margin_drive_out(), .margin_drive_oe_n,
    .seq_timeout, .page_target, .page_index, .page_bus_addr, .page_all,
    .page_gpio_cfg, .status_cml, .vendor_summary_flag, .wdog_flag,
    .alert_n, .chip_reset);
  smpw_peer smpw_peer_inst (.mclk, .sys_rst, .pull_line(peer_pull),
    .shutdown_oe_n(peer_sd_oe_n), .sig_oe_n(peer_sq_oe_n));
  // Background restart keeps the watchdog quiet between tests.
  always @(negedge mclk) begin
    kcnt <= (kcnt == KICK_CYC - 1) ? 0 : kcnt + 1;
    wdog_kick <= kick_en && kcnt == 0;
    if (chip_reset === 1'b1) bites <= bites + 1;
  end
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic send(input logic wr, input logic [7:0] c, d);
    @(negedge mclk);
    {cmd_wr, cmd_rd, cmd_code, cmd_data} = {wr, !wr, c, d};
    @(negedge mclk);
    {cmd_wr, cmd_rd} = 2'b00;
  endtask : send
  task automatic clr;
    @(negedge mclk) clear_faults = 1'b1;
    @(negedge mclk) clear_faults = 1'b0;
  endtask : clr
  function automatic logic [3:0] exp_tgt(input logic [7:0] v);
    return v < 8'h0C ? 4'h1 : v < 8'h10 ? 4'h2 : 4'h4;
  endfunction : exp_tgt
  function automatic logic [7:0] exp_addr(input logic [7:0] v);
    return v < 8'h10 ? 8'hA0 : 8'h90 + ((v - 8'h11) << 1);
  endfunction : exp_addr
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("BAD %0t run hung", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(28));
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (1) @(negedge mclk);
    chk(page_index === 5'h00 && supply_enable_oe_n === 12'hFFF, "reset");
    cur = 8'h00;
    for (i = 0; i < 27; i++) begin
      p = i < 21 ? 8'(i) : i == 26 ? 8'hFF : 8'($urandom_range(21, 254));
      p = i == 21 ? 8'h15 : i == 22 ? 8'hFE : p;
      rsv = p > 8'h14 && p != 8'hFF;
      send(1'b1, 8'h00, p);
      inv = 1'b0;
      repeat (3) begin
        inv |= cmd_invalid === 1'b1;
        @(negedge mclk);
      end
      if (rsv) begin
        chk(inv && page_index === cur[4:0], "reserved page");
        chk(status_cml === 1'b1, "reserved flag");
        clr();
      end else begin
        chk(!inv && page_all === (p == 8'hFF), "page all");
        if (p != 8'hFF) begin
          chk(page_index === p[4:0] && page_target === exp_tgt(p), "map");
          chk(page_gpio_cfg === (p < 8'h0C), "gpio page");
          if ((p[3] && !p[2]) || p > 8'h10) chk(page_bus_addr === exp_addr(p), "ad");
        end
        cur = p;
      end
      send(1'b0, 8'h00, 8'h00);
      for (n = 0; cmd_rvalid !== 1'b1 && n < 3; n++) @(negedge mclk);
      chk(cmd_rvalid === 1'b1 && cmd_rdata === cur, "read back");
    end
    $display("test page done");
    cmd_on_page = 1'b0;
    send(1'b1, 8'($urandom_range(1, 255)), 8'($urandom));
    repeat (2) @(negedge mclk);
    chk(status_cml === 1'b1, "unsupported");
    clr();
    cmd_common = 1'b1;
    send(1'b1, 8'($urandom_range(1, 255)), 8'($urandom));
    repeat (2) @(negedge mclk);
    chk(status_cml === 1'b0, "common command");
    {cmd_common, cmd_on_page} = 2'b01;
    $display("test status done");
    sig_emit_en[1] = 1'b1;
    sig_code[7:4] = 4'($urandom_range(1, 15));
    power_good[1] = 1'b1;
    for (n = 0; dev_sq_oe_n !== 1'b0 && n < 9000; n++) @(negedge mclk);
    chk(dev_sq_oe_n === 1'b0, "signature sent");
    {seq_wait_en[3], sig_wait_code[15:12], chan_start[3]} = 6'h3F;
    event_wait_limit = 16'h001E;
    for (n = 0; seq_timeout[3] !== 1'b1 && n < 60; n++) @(negedge mclk);
    chk(seq_timeout[3] === 1'b1 && n >= 25, "wait limit");
    chan_start[3] = 1'b0;
    repeat (5) @(negedge mclk);
    {event_wait_limit, chan_start[3]} = 17'h00001;
    for (n = 0; seq_timeout[3] !== 1'b1 && n < 200; n++) @(negedge mclk);
    chk(n == 200, "no limit");
    chk((supply_enable_out[3] & ~supply_enable_oe_n[3]) === 1'b0, "hold");
    $display("test sequence done");
    {seq_wait_en, fault_resp_en, power_good, chan_start} = {12'h0, {36{1'b1}}};
    repeat (10) @(negedge mclk);
    peer_pull = 3'b001;
    repeat (4) @(negedge mclk);
    chk((supply_enable_out & ~supply_enable_oe_n) === 12'h000, "shut");
    peer_pull = 3'b000;
    {fault_drive_en[4], chan_fault[4]} = 2'b11;
    repeat (4) @(negedge mclk);
    chk(dev_sd_oe_n === 3'b110, "fault drive");
    {second_fault_en, third_fault_en} = 2'b11;
    repeat (4) @(negedge mclk);
    chk(dev_sd_oe_n === 3'b000, "extra lines");
    chk(supply_enable_oe_n[10] & margin_drive_oe_n[7], "lines reuse");
    chan_fault = 12'h000;
    clr();
    $display("test fault done");
    chk(bites == 0, "bite while restarted");
    {alert_en, cfg_reload_done, kick_en} = 3'b100;
    for (n = 0; bites == 0 && n < BITE_CYC + 20; n++) @(negedge mclk);
    chk(bites == 1 && n >= BITE_CYC - KICK_CYC - 5, "bite time");
    repeat (3) @(negedge mclk);
    chk(wdog_flag & vendor_summary_flag & !alert_n, "bite flags");
    chk(cfg_reload === 1'b1, "reload start");
    {cfg_reload_done, kick_en} = 2'b11;
    for (n = 0; cfg_reload !== 1'b0 && n < 10; n++) @(negedge mclk);
    chk(cfg_reload === 1'b0, "reload end");
    $display("test watchdog done");
    {sys_rst, mem_check_ok} = 2'b10;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
    chk(dev_sd_oe_n === 3'b110 && dev_sq_oe_n === 1'b1, "null lines");
    chk(supply_enable_oe_n === 12'hFFF && &margin_drive_oe_n, "null");
    $display("test memory check done");
    print_verdict();
  end
endmodule : testbench
bind smpw_core smpw_checker #(.BITE_CYC(BITE_CYC)) smpw_checker_inst (
  .mclk, .sys_rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_data, .cmd_common,
  .cmd_on_page, .cmd_invalid, .mem_check_done, .mem_check_ok, .cfg_reload,
  .wdog_kick, .chip_reset, .alert_en, .third_fault_en,
  .shared_shutdown_line_oe_n, .supply_enable_oe_n, .page_target,
  .page_index, .page_bus_addr, .page_all, .page_gpio_cfg, .status_cml,
  .vendor_summary_flag, .wdog_flag, .alert_n);
